// *** sim/lmfr_host_model.sv ***
`timescale 1ns/10ps
module lmfr_host_model (
    // Clock
    input wire logic clk_i,
    // Register port
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    logic [7:0] exp_q[$];

    initial
    begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // Idle lines show the inverse, so a stale address or byte cannot pass
    task automatic release_bus();
        reg_addr_o = ~reg_addr_o;
        reg_wdata_o = ~reg_wdata_o;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge clk_i);
        reg_wr_o = 1'b0;
        release_bus();
    endtask

    // Expected byte is noted before the strobe goes out
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(negedge clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge clk_i);
        reg_rd_o = 1'b0;
        release_bus();
    endtask

    // Detection needs a low current and no resistors
    task automatic prep_detect();
        wr(8'h51, 8'h20);
        wr(8'h52, 8'h00);
    endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/10ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("[FAIL] %s exp %h seen %h", n, e, g); end end
module tb;
    logic clk_i, rst_i, en_i, reg_wr, reg_rd, shdn_n, sink_only, busy, phase, sp_en;
    logic [7:0] reg_addr, reg_wdata, rdata, die_temp, gcl, v, e_rd;
    logic [71:0] open_f, short_f;
    logic [95:0] r96;
    logic [3:0] rows;
    logic [6:0] pct;
    logic [2:0] pd, pu, fcode;
    logic [1:0] spread_range, spread_cycle;
    int errors = 0;
    int tests_run = 0;
    int i, n;
    logic [3:0] scan_c [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9};
    logic [3:0] scan_r [5] = '{4'hF, 4'h7, 4'h3, 4'h0, 4'hF};
    logic [7:0] tt [4] = '{8'h8C, 8'h78, 8'h64, 8'h5A};
    logic [6:0] pc [4] = '{7'h64, 7'h4B, 7'h37, 7'h1E};

    lmfr_host_model host_u (.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd),
        .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));

    lmfr_function_regs #(.DETECT_WAIT(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(rdata), .open_flags_i(open_f), .short_flags_i(short_f),
        .die_temp_i(die_temp), .shutdown_n_o(shdn_n), .row_enable_o(rows),
        .sink_only_o(sink_only), .global_current_level_o(gcl), .current_pct_o(pct),
        .detect_busy_o(busy), .phase_choice_o(phase), .row_pulldown_sel_o(pd),
        .column_pullup_sel_o(pu), .spread_enable_o(sp_en), .spread_range_o(spread_range),
        .spread_cycle_o(spread_cycle), .pwm_freq_code_o(fcode));

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Read data lands on the edge that takes the strobe
    always @(posedge clk_i)
    begin
        if (reg_rd === 1'b1)
        begin
            #1;
            e_rd = host_u.exp_q.pop_front();
            `CHK("reg_rdata_o", e_rd, rdata)
        end
    end

    task automatic close_out();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wait_busy(input logic lvl);
        for (n = 0; n < 40 && busy !== lvl; n++)
            @(negedge clk_i);
        if (busy !== lvl)
        begin
            errors++;
            close_out();
        end
    endtask

    task automatic check_results(input logic [71:0] f);
        for (int k = 0; k < 12; k++)
            host_u.rd(8'h53 + k[7:0], {2'b00, f[k*6 +: 6]});
    endtask

    initial
    begin
        en_i = 1'b1;
        rst_i = 1'b1;
        die_temp = 8'h00;
        open_f = '0;
        short_f = '0;
        v = 8'($urandom(32'h7BAA));
        repeat (20) @(negedge clk_i);
        rst_i = 1'b0;
        @(negedge clk_i);
        `CHK("shutdown_n_o", 1'b0, shdn_n)
        `CHK("row_enable_o", 4'h0, rows)
        `CHK("global_current_level_o", 8'h00, gcl)
        `CHK("current_pct_o", 7'h64, pct)
        `CHK("row_pulldown_sel_o", 3'h3, pd)
        `CHK("column_pullup_sel_o", 3'h3, pu)
        `CHK("spread_enable_o", 1'b0, sp_en)
        `CHK("pwm_freq_code_o", 3'h0, fcode)
        host_u.rd(8'h52, 8'h33);
        host_u.rd(8'h50, 8'h00);
        host_u.rd(8'h70, 8'h00);
        for (i = 0; i < 5; i++)
        begin
            host_u.wr(8'h50, {scan_c[i], 4'h1});
            `CHK("row_enable_o", scan_r[i], rows)
            `CHK("sink_only_o", 1'(scan_c[i] == 4'h3), sink_only)
        end
        host_u.wr(8'h50, 8'h00);
        `CHK("row_enable_o", 4'h0, rows)
        v = 8'($urandom);
        host_u.wr(8'h51, v);
        `CHK("global_current_level_o", v, gcl)
        host_u.rd(8'h51, v);
        // A write while the enable is low must leave the global current level frozen
        en_i = 1'b0;
        host_u.wr(8'h51, ~v);
        `CHK("global_current_level_o", v, gcl)
        en_i = 1'b1;
        for (i = 0; i < 8; i++)
        begin
            v = {i[0], i[2:0], 1'b1, ~i[2:0]};
            host_u.wr(8'h52, v);
            `CHK("row_pulldown_sel_o", i[2:0], pd)
            `CHK("column_pullup_sel_o", ~i[2:0], pu)
            `CHK("phase_choice_o", i[0], phase)
            host_u.rd(8'h52, {v[7:4], 1'b0, v[2:0]});
        end
        for (i = 0; i < 16; i++)
        begin
            host_u.wr(8'h5F, {4'hF, i[3:0]});
            host_u.rd(8'h5F, {4'h0, i[3:0]});
            die_temp = tt[i[3:2]] - 8'h01;
            repeat (2) @(negedge clk_i);
            `CHK("current_pct_o", 7'h64, pct)
            die_temp = tt[i[3:2]];
            repeat (2) @(negedge clk_i);
            `CHK("current_pct_o", pc[i[1:0]], pct)
        end
        v = 8'($urandom);
        host_u.wr(8'h60, v);
        `CHK("spread_enable_o", v[4], sp_en)
        `CHK("spread_range_o", v[3:2], spread_range)
        `CHK("spread_cycle_o", v[1:0], spread_cycle)
        host_u.rd(8'h60, {3'h0, v[4:0]});
        host_u.wr(8'hE2, 8'hA0);
        `CHK("pwm_freq_code_o", 3'h0, fcode)
        host_u.wr(8'hE0, 8'h01);
        for (i = 0; i < 8; i++)
        begin
            host_u.wr(8'hE2, {i[2:0], 5'h1F});
            `CHK("pwm_freq_code_o", i[2:0], fcode)
        end
        host_u.rd(8'hE0, 8'h00);
        host_u.wr(8'hE0, 8'h00);
        host_u.wr(8'hE2, 8'h20);
        `CHK("pwm_freq_code_o", 3'h7, fcode)
        r96 = {$urandom, $urandom, $urandom};
        open_f = r96[71:0];
        short_f = ~open_f;
        host_u.prep_detect();
        host_u.wr(8'h50, 8'h03);
        wait_busy(1'b1);
        wait_busy(1'b0);
        `CHK("busy cycles", 8, n)
        host_u.wr(8'h53, 8'hFF);
        check_results(open_f);
        host_u.wr(8'h50, 8'h03);
        repeat (4) @(negedge clk_i);
        `CHK("detect_busy_o", 1'b0, busy)
        host_u.wr(8'h50, 8'h05);
        repeat (4) @(negedge clk_i);
        `CHK("detect_busy_o", 1'b0, busy)
        host_u.wr(8'h50, 8'h01);
        host_u.wr(8'h50, 8'h05);
        wait_busy(1'b1);
        wait_busy(1'b0);
        check_results(short_f);
        host_u.wr(8'h51, 8'h55);
        host_u.wr(8'h8F, 8'h12);
        `CHK("global_current_level_o", 8'h55, gcl)
        host_u.wr(8'h8F, 8'hAE);
        `CHK("global_current_level_o", 8'h00, gcl)
        `CHK("row_pulldown_sel_o", 3'h3, pd)
        `CHK("pwm_freq_code_o", 3'h0, fcode)
        host_u.rd(8'h53, 8'h00);
        host_u.rd(8'h8F, 8'h00);
        close_out();
    end
endmodule

// *** verilog/lmfr_detect_engine.sv ***
`timescale 1ns/10ps
module lmfr_detect_engine #(
    parameter int WAIT_CYC = lmfr_pkg::DETECT_CYC,
    parameter int CW = $clog2(WAIT_CYC + 1)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic [lmfr_pkg::FAULT_BITS-1:0] open_flags_i,
    input wire logic [lmfr_pkg::FAULT_BITS-1:0] short_flags_i,
    lmfr_detect_if.eng det
);
    typedef struct packed {
        lmfr_pkg::lmfr_det_state_t st;
        logic kind_short;
        logic [CW-1:0] cnt;
        logic [lmfr_pkg::FAULT_BITS-1:0] flags;
    } lmfr_eng_state_t;

    localparam logic [CW-1:0] WAIT_LAST = CW'(WAIT_CYC - 1);

    lmfr_eng_state_t s_ff;
    lmfr_eng_state_t nxt_s;

    always_comb
    begin
        nxt_s = s_ff;
        unique case (s_ff.st)
            lmfr_pkg::LMFR_DET_IDLE:
            begin
                if (det.trig)
                begin
                    nxt_s.st = lmfr_pkg::LMFR_DET_WAIT;
                    nxt_s.kind_short = det.kind_short;
                    nxt_s.cnt = '0;
                end
            end
            lmfr_pkg::LMFR_DET_WAIT:
            begin
                // Results are stored only once the wait is over
                if (s_ff.cnt == WAIT_LAST)
                begin
                    nxt_s.st = lmfr_pkg::LMFR_DET_IDLE;
                    nxt_s.flags = s_ff.kind_short ? short_flags_i : open_flags_i;
                end
                else
                begin
                    nxt_s.cnt = s_ff.cnt + CW'(1);
                end
            end
        endcase
        // Soft reset abandons a running check and clears the results
        if (det.clear)
        begin
            nxt_s.st = lmfr_pkg::LMFR_DET_IDLE;
            nxt_s.cnt = '0;
            nxt_s.flags = '0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_ff <= '0;
        end
        else if (en_i)
        begin
            s_ff <= nxt_s;
        end
    end

    assign det.busy = (s_ff.st == lmfr_pkg::LMFR_DET_WAIT);
    assign det.flags = s_ff.flags;
endmodule

// *** verilog/lmfr_detect_if.sv ***
`timescale 1ns/10ps
interface lmfr_detect_if;
    logic trig;
    logic kind_short;
    logic clear;
    logic busy;
    logic [lmfr_pkg::FAULT_BITS-1:0] flags;

    modport ctrl (
        output trig,
        output kind_short,
        output clear,
        input busy,
        input flags
    );
    modport eng (
        input trig,
        input kind_short,
        input clear,
        output busy,
        output flags
    );
endinterface

// *** verilog/lmfr_function_regs.sv ***
`timescale 1ns/10ps
// What this block does
// - Write 01 after 00 starts one open check
// - Write 10 after 00 starts one short check
// - Shutdown bit 0 keeps rows off
// - Scan select sets row duty, default quarter
// - Scan codes: four, three, two rows, none
// - Eight-bit global current level, resets zero
// - Phase bit7, pulldown 6:4, pullup 2:0, 011
// - Phase choice 1 gives 180 degree delay
// - Row pulldown: eight resistor choices
// - Column pullup: eight resistor choices
// - Twelve read-only result bytes, bits 7:6 zero
// - Finished check stores per-LED results
// - Threshold code picks roll-off start temperature
// - At or above threshold, derate code scales current
// - Spread enable bit 4, resets off
// - Spread range and cycle time fields
// - Key 0xAE restores all defaults
// - Power-up gives defaults, blank display
// - Frequency unlock bit 0, resets zero
// - Frequency code in bits 7:5
module lmfr_function_regs #(
    parameter int DETECT_WAIT = lmfr_pkg::DETECT_CYC
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    // Register access from the serial interface
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Analog detection flags and die temperature
    input wire logic [lmfr_pkg::FAULT_BITS-1:0] open_flags_i,
    input wire logic [lmfr_pkg::FAULT_BITS-1:0] short_flags_i,
    input wire logic [7:0] die_temp_i,
    // Matrix control
    output logic shutdown_n_o,
    output logic [3:0] row_enable_o,
    output logic sink_only_o,
    output logic [7:0] global_current_level_o,
    output logic [6:0] current_pct_o,
    output logic detect_busy_o,
    // Resistors and phase
    output logic phase_choice_o,
    output logic [2:0] row_pulldown_sel_o,
    output logic [2:0] column_pullup_sel_o,
    // Spread spectrum and PWM frequency
    output logic spread_enable_o,
    output logic [1:0] spread_range_o,
    output logic [1:0] spread_cycle_o,
    output logic [2:0] pwm_freq_code_o
);
    typedef struct packed {
        logic shutdown_n;
        logic [1:0] detect_sel;
        logic [3:0] scan_sel;
        logic [3:0] rows;
        logic sink_only;
        logic [7:0] gcl;
        logic phase;
        logic [2:0] pd;
        logic [2:0] pu;
        logic [1:0] thr;
        logic [1:0] der;
        logic ss_en;
        logic [1:0] ss_rng;
        logic [1:0] ss_clt;
        logic freq_en;
        logic [2:0] freq;
        logic [6:0] pct;
        logic trig;
        logic kind_short;
        logic clear;
        logic [7:0] rdata;
    } lmfr_regs_state_t;

    lmfr_regs_state_t s_ff;
    lmfr_regs_state_t nxt_s;
    lmfr_detect_if det ();

    function automatic logic [4:0] scan_decode(input logic [3:0] code);
        unique case (code)
            lmfr_pkg::SCAN_THREE: scan_decode = {lmfr_pkg::ROWS_THREE, 1'b0};
            lmfr_pkg::SCAN_TWO: scan_decode = {lmfr_pkg::ROWS_TWO, 1'b0};
            lmfr_pkg::SCAN_NONE: scan_decode = {lmfr_pkg::ROWS_NONE, 1'b1};
            default: scan_decode = {lmfr_pkg::ROWS_FOUR, 1'b0};
        endcase
    endfunction

    function automatic logic [7:0] temp_point(input logic [1:0] code);
        unique case (code)
            2'h0: temp_point = lmfr_pkg::TEMP_TH0;
            2'h1: temp_point = lmfr_pkg::TEMP_TH1;
            2'h2: temp_point = lmfr_pkg::TEMP_TH2;
            2'h3: temp_point = lmfr_pkg::TEMP_TH3;
        endcase
    endfunction

    function automatic logic [6:0] derate_pct(input logic [1:0] code);
        unique case (code)
            2'h0: derate_pct = lmfr_pkg::PCT_FULL;
            2'h1: derate_pct = lmfr_pkg::PCT_D1;
            2'h2: derate_pct = lmfr_pkg::PCT_D2;
            2'h3: derate_pct = lmfr_pkg::PCT_D3;
        endcase
    endfunction

    function automatic lmfr_regs_state_t defaults();
        lmfr_regs_state_t d;
        d = '0;
        d.scan_sel = lmfr_pkg::RST_OP_CONFIG[7:4];
        d.rows = lmfr_pkg::ROWS_FOUR;
        d.gcl = lmfr_pkg::RST_GLOBAL_CURRENT;
        d.pd = lmfr_pkg::RST_RES_SEL;
        d.pu = lmfr_pkg::RST_RES_SEL;
        d.freq = lmfr_pkg::RST_PWM_FREQ;
        d.pct = lmfr_pkg::PCT_FULL;
        return d;
    endfunction

    logic [3:0] fault_idx;
    logic [lmfr_pkg::FAULT_COLS-1:0] fault_byte;
    logic wr_cfg;
    logic [1:0] wr_det;

    assign fault_idx = 4'(reg_addr_i - lmfr_pkg::ADDR_FAULT_FIRST);
    assign fault_byte = det.flags[fault_idx * lmfr_pkg::FAULT_COLS +: lmfr_pkg::FAULT_COLS];
    assign wr_cfg = reg_wr_i && (reg_addr_i == lmfr_pkg::ADDR_OP_CONFIG);
    assign wr_det = reg_wdata_i[lmfr_pkg::CFG_DET_LSB +: 2];

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.trig = 1'b0;
        nxt_s.clear = 1'b0;
        // Temperature roll-off follows the die continuously
        nxt_s.pct = (die_temp_i >= temp_point(s_ff.thr)) ? derate_pct(s_ff.der)
                                                          : lmfr_pkg::PCT_FULL;
        if (reg_wr_i)
        begin
            unique case (reg_addr_i)
                lmfr_pkg::ADDR_OP_CONFIG:
                begin
                    nxt_s.shutdown_n = reg_wdata_i[lmfr_pkg::CFG_SHDN_BIT];
                    nxt_s.scan_sel = reg_wdata_i[lmfr_pkg::CFG_SCAN_LSB +: 4];
                    {nxt_s.rows, nxt_s.sink_only} =
                        scan_decode(reg_wdata_i[lmfr_pkg::CFG_SCAN_LSB +: 4]);
                    nxt_s.detect_sel = wr_det;
                    // Re-arming needs the field to pass through 00 first
                    if (s_ff.detect_sel == lmfr_pkg::DET_OFF &&
                        (wr_det == lmfr_pkg::DET_OPEN || wr_det == lmfr_pkg::DET_SHORT))
                    begin
                        nxt_s.trig = 1'b1;
                        nxt_s.kind_short = (wr_det == lmfr_pkg::DET_SHORT);
                    end
                end
                lmfr_pkg::ADDR_GLOBAL_CURRENT:
                begin
                    nxt_s.gcl = reg_wdata_i;
                end
                lmfr_pkg::ADDR_RESISTOR_PHASE:
                begin
                    nxt_s.phase = reg_wdata_i[lmfr_pkg::RES_PHASE_BIT];
                    nxt_s.pd = reg_wdata_i[lmfr_pkg::RES_PD_LSB +: 3];
                    nxt_s.pu = reg_wdata_i[lmfr_pkg::RES_PU_LSB +: 3];
                end
                lmfr_pkg::ADDR_THERMAL:
                begin
                    nxt_s.thr = reg_wdata_i[lmfr_pkg::TH_THR_LSB +: 2];
                    nxt_s.der = reg_wdata_i[lmfr_pkg::TH_DER_LSB +: 2];
                end
                lmfr_pkg::ADDR_SPREAD:
                begin
                    nxt_s.ss_en = reg_wdata_i[lmfr_pkg::SS_EN_BIT];
                    nxt_s.ss_rng = reg_wdata_i[lmfr_pkg::SS_RNG_LSB +: 2];
                    nxt_s.ss_clt = reg_wdata_i[lmfr_pkg::SS_CLT_LSB +: 2];
                end
                lmfr_pkg::ADDR_SOFT_RESET:
                begin
                    if (reg_wdata_i == lmfr_pkg::SOFT_RESET_KEY)
                    begin
                        nxt_s = defaults();
                        nxt_s.clear = 1'b1;
                    end
                end
                lmfr_pkg::ADDR_FREQ_UNLOCK:
                begin
                    nxt_s.freq_en = reg_wdata_i[lmfr_pkg::FREQ_EN_BIT];
                end
                lmfr_pkg::ADDR_FREQ_SET:
                begin
                    if (s_ff.freq_en)
                    begin
                        nxt_s.freq = reg_wdata_i[lmfr_pkg::FREQ_CODE_LSB +: 3];
                    end
                end
                default:
                begin
                end
            endcase
        end
        if (reg_rd_i)
        begin
            nxt_s.rdata = 8'h00;
            if (reg_addr_i >= lmfr_pkg::ADDR_FAULT_FIRST &&
                reg_addr_i <= lmfr_pkg::ADDR_FAULT_LAST)
            begin
                nxt_s.rdata = {2'h0, fault_byte};
            end
            else
            begin
                unique case (reg_addr_i)
                    lmfr_pkg::ADDR_OP_CONFIG:
                        nxt_s.rdata = {s_ff.scan_sel, 1'b0, s_ff.detect_sel, s_ff.shutdown_n};
                    lmfr_pkg::ADDR_GLOBAL_CURRENT:
                        nxt_s.rdata = s_ff.gcl;
                    lmfr_pkg::ADDR_RESISTOR_PHASE:
                        nxt_s.rdata = {s_ff.phase, s_ff.pd, 1'b0, s_ff.pu};
                    lmfr_pkg::ADDR_THERMAL:
                        nxt_s.rdata = {4'h0, s_ff.thr, s_ff.der};
                    lmfr_pkg::ADDR_SPREAD:
                        nxt_s.rdata = {3'h0, s_ff.ss_en, s_ff.ss_rng, s_ff.ss_clt};
                    default:
                        nxt_s.rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_ff <= defaults();
        end
        else if (en_i)
        begin
            s_ff <= nxt_s;
        end
    end

    assign det.trig = s_ff.trig;
    assign det.kind_short = s_ff.kind_short;
    assign det.clear = s_ff.clear;

    // The check waits out the scans itself; the host keeps current and resistors set
    lmfr_detect_engine #(
        .WAIT_CYC(DETECT_WAIT)
    ) u_engine (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(en_i),
        .open_flags_i(open_flags_i),
        .short_flags_i(short_flags_i),
        .det(det.eng)
    );

    assign reg_rdata_o = s_ff.rdata;
    assign shutdown_n_o = s_ff.shutdown_n;
    assign row_enable_o = s_ff.shutdown_n ? s_ff.rows : 4'h0;
    assign sink_only_o = s_ff.sink_only;
    assign global_current_level_o = s_ff.gcl;
    assign current_pct_o = s_ff.pct;
    assign detect_busy_o = det.busy;
    assign phase_choice_o = s_ff.phase;
    assign row_pulldown_sel_o = s_ff.pd;
    assign column_pullup_sel_o = s_ff.pu;
    assign spread_enable_o = s_ff.ss_en;
    assign spread_range_o = s_ff.ss_rng;
    assign spread_cycle_o = s_ff.ss_clt;
    assign pwm_freq_code_o = s_ff.freq;

    sequence seq_arm_write;
        en_i && wr_cfg && s_ff.detect_sel == lmfr_pkg::DET_OFF;
    endsequence

    sequence seq_key_write;
        en_i && reg_wr_i && reg_addr_i == lmfr_pkg::ADDR_SOFT_RESET &&
            reg_wdata_i == lmfr_pkg::SOFT_RESET_KEY;
    endsequence

    a_open_trigger: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_arm_write ##0 (wr_det == lmfr_pkg::DET_OPEN) |=> s_ff.trig && !s_ff.kind_short
            ##1 (!$past(en_i) || det.busy))
        else $error("open check not started");

    a_short_trigger: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_arm_write ##0 (wr_det == lmfr_pkg::DET_SHORT) |=> s_ff.trig && s_ff.kind_short)
        else $error("short check not started");

    a_no_rearm: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && wr_cfg && s_ff.detect_sel != lmfr_pkg::DET_OFF |=> !s_ff.trig)
        else $error("check restarted without passing through off");

    a_shutdown_rows: assert property (@(posedge clk_i) disable iff (rst_i)
        !shutdown_n_o |-> row_enable_o == 4'h0)
        else $error("rows driven in shutdown");

    a_scan_three: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && wr_cfg && reg_wdata_i[7:4] == lmfr_pkg::SCAN_THREE && reg_wdata_i[0]
            |=> row_enable_o == lmfr_pkg::ROWS_THREE && !sink_only_o)
        else $error("three-row scan not applied");

    a_fault_read: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && reg_rd_i && reg_addr_i >= lmfr_pkg::ADDR_FAULT_FIRST &&
            reg_addr_i <= lmfr_pkg::ADDR_FAULT_LAST |=> reg_rdata_o[7:6] == 2'h0)
        else $error("result byte upper bits not zero");

    a_key_defaults: assert property (@(posedge clk_i) disable iff (rst_i)
        seq_key_write |=> global_current_level_o == 8'h00 && row_pulldown_sel_o == 3'h3 &&
            column_pullup_sel_o == 3'h3 && !shutdown_n_o && pwm_freq_code_o == 3'h0)
        else $error("soft reset left a register changed");

    a_freq_locked: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && reg_wr_i && reg_addr_i == lmfr_pkg::ADDR_FREQ_SET && !s_ff.freq_en
            |=> $stable(pwm_freq_code_o))
        else $error("locked frequency changed");

    a_freq_unlocked: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && reg_wr_i && reg_addr_i == lmfr_pkg::ADDR_FREQ_SET && s_ff.freq_en
            |=> pwm_freq_code_o == $past(reg_wdata_i[7:5]))
        else $error("frequency code not taken");

    a_derate_hot: assert property (@(posedge clk_i) disable iff (rst_i)
        en_i && s_ff.der == 2'h3 && s_ff.thr == 2'h0 && die_temp_i >= 8'h8C
            |=> current_pct_o == 7'h1E)
        else $error("roll-off percentage wrong");
endmodule

// *** verilog/lmfr_pkg.sv ***
package lmfr_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_OP_CONFIG = 8'h50;
    localparam logic [7:0] ADDR_GLOBAL_CURRENT = 8'h51;
    localparam logic [7:0] ADDR_RESISTOR_PHASE = 8'h52;
    localparam logic [7:0] ADDR_FAULT_FIRST = 8'h53;
    localparam logic [7:0] ADDR_FAULT_LAST = 8'h5E;
    localparam logic [7:0] ADDR_THERMAL = 8'h5F;
    localparam logic [7:0] ADDR_SPREAD = 8'h60;
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h8F;
    localparam logic [7:0] ADDR_FREQ_UNLOCK = 8'hE0;
    localparam logic [7:0] ADDR_FREQ_SET = 8'hE2;
    localparam logic [7:0] SOFT_RESET_KEY = 8'hAE;

    // Reset values
    localparam logic [7:0] RST_OP_CONFIG = 8'h00;
    localparam logic [7:0] RST_GLOBAL_CURRENT = 8'h00;
    localparam logic [2:0] RST_RES_SEL = 3'h3;
    localparam logic [2:0] RST_PWM_FREQ = 3'h0;

    // Detection select codes
    localparam logic [1:0] DET_OFF = 2'h0;
    localparam logic [1:0] DET_OPEN = 2'h1;
    localparam logic [1:0] DET_SHORT = 2'h2;

    // Scan select codes and row patterns
    localparam logic [3:0] SCAN_FOUR = 4'h0;
    localparam logic [3:0] SCAN_THREE = 4'h1;
    localparam logic [3:0] SCAN_TWO = 4'h2;
    localparam logic [3:0] SCAN_NONE = 4'h3;
    localparam logic [3:0] ROWS_FOUR = 4'hF;
    localparam logic [3:0] ROWS_THREE = 4'h7;
    localparam logic [3:0] ROWS_TWO = 4'h3;
    localparam logic [3:0] ROWS_NONE = 4'h0;

    // Resistor choices, same encoding for rows and columns
    localparam logic [2:0] RES_NONE = 3'h0;
    localparam logic [2:0] RES_0K5_OFF = 3'h1;
    localparam logic [2:0] RES_1K_OFF = 3'h2;
    localparam logic [2:0] RES_2K_OFF = 3'h3;
    localparam logic [2:0] RES_1K_ALWAYS = 3'h4;
    localparam logic [2:0] RES_2K_ALWAYS = 3'h5;
    localparam logic [2:0] RES_4K_ALWAYS = 3'h6;
    localparam logic [2:0] RES_8K_ALWAYS = 3'h7;

    // Field positions
    localparam int CFG_SCAN_LSB = 4;
    localparam int CFG_DET_LSB = 1;
    localparam int CFG_SHDN_BIT = 0;
    localparam int RES_PHASE_BIT = 7;
    localparam int RES_PD_LSB = 4;
    localparam int RES_PU_LSB = 0;
    localparam int TH_THR_LSB = 2;
    localparam int TH_DER_LSB = 0;
    localparam int SS_EN_BIT = 4;
    localparam int SS_RNG_LSB = 2;
    localparam int SS_CLT_LSB = 0;
    localparam int FREQ_EN_BIT = 0;
    localparam int FREQ_CODE_LSB = 5;

    // Roll-off start temperatures in degrees C, per threshold code
    localparam logic [7:0] TEMP_TH0 = 8'h8C;
    localparam logic [7:0] TEMP_TH1 = 8'h78;
    localparam logic [7:0] TEMP_TH2 = 8'h64;
    localparam logic [7:0] TEMP_TH3 = 8'h5A;
    // Output current percentage per derate code
    localparam logic [6:0] PCT_FULL = 7'h64;
    localparam logic [6:0] PCT_D1 = 7'h4B;
    localparam logic [6:0] PCT_D2 = 7'h37;
    localparam logic [6:0] PCT_D3 = 7'h1E;

    // Detection matrix: twelve result bytes of six column flags
    localparam int FAULT_REGS = 12;
    localparam int FAULT_COLS = 6;
    localparam int FAULT_BITS = FAULT_REGS * FAULT_COLS;

    // Detection waits two full scan cycles of four row slots
    localparam int CLK_PERIOD_NS = 50;
    localparam int ROW_SLOT_NS = 34130;
    localparam int SCAN_ROWS = 4;
    localparam int DETECT_SCANS = 2;
    localparam int DETECT_NS = DETECT_SCANS * SCAN_ROWS * ROW_SLOT_NS;
    localparam int DETECT_CYC = (DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [0:0] {
        LMFR_DET_IDLE,
        LMFR_DET_WAIT
    } lmfr_det_state_t;
endpackage
